// file: common/ccr_pkg.sv
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_FLAGS      = 4'h0;
  localparam logic [3:0] IDX_SP         = 4'h2;
  localparam logic [3:0] IDX_CLK_MODE   = 4'h3;
  localparam logic [3:0] IDX_IRQ_EN     = 4'h4;
  localparam logic [3:0] IDX_IRQ_REQ    = 4'h5;
  localparam logic [3:0] IDX_TIMER_MODE = 4'h6;
  localparam logic [3:0] IDX_AUX_CTRL   = 4'h7;
  localparam logic [3:0] IDX_COUNT_LO   = 4'h8;
  localparam logic [3:0] IDX_COUNT_HI   = 4'h9;

  // ----------------------------------------------------------------
  // Reset values and fixed bit patterns
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_FLAGS      = 4'h0;
  localparam logic [7:0]  FLAGS_RSVD     = 8'hf0;
  localparam logic [7:0]  RST_SP         = 8'h00;
  localparam logic [7:0]  RST_CLK_MODE   = 8'hf6;
  localparam logic [7:0]  RST_IRQ_EN     = 8'h00;
  localparam logic [7:0]  RST_IRQ_REQ    = 8'h00;
  localparam logic [7:0]  IRQ_USED       = 8'h55;
  localparam logic [7:0]  RST_TIMER_MODE = 8'h00;
  localparam logic [7:0]  RST_AUX_CTRL   = 8'h01;
  localparam logic [15:0] RESTART_ADDR   = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CLK_FAST_EN  = 4;
  localparam int CLK_TYPE     = 3;
  localparam int CLK_SLOW_EN  = 2;
  localparam int CLK_WDOG_EN  = 1;
  localparam int CLK_PIN_SEL  = 0;
  localparam int IRQ_SECOND   = 6;
  localparam int IRQ_CMP      = 4;
  localparam int IRQ_WIDE     = 2;
  localparam int IRQ_EXT      = 0;
  localparam int AUX_DIGIN_EN = 0;
  localparam int AUX_T_EDGE   = 4;

  // ----------------------------------------------------------------
  // Wide timer source codes and prescale limits
  // ----------------------------------------------------------------
  localparam logic [2:0] TSRC_OFF  = 3'h0;
  localparam logic [2:0] TSRC_SYS  = 3'h1;
  localparam logic [2:0] TSRC_PIN2 = 3'h3;
  localparam logic [2:0] TSRC_FAST = 3'h4;
  localparam logic [2:0] TSRC_SLOW = 3'h6;
  localparam logic [2:0] TSRC_EXT  = 3'h7;
  localparam logic [5:0] PRE_DIV1  = 6'h00;
  localparam logic [5:0] PRE_DIV4  = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PRE_DIV64 = 6'h3f;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ALU_ADD   = 2'h0,
    ALU_SUB   = 2'h1,
    ALU_LOGIC = 2'h2,
    ALU_SHIFT = 2'h3
  } ccr_alu_op_t;

  typedef struct packed {
    logic        valid;
    ccr_alu_op_t op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  res;
    logic        shift_c;
  } ccr_alu_t;

  typedef enum logic [1:0] {
    CAUSE_POWER_ON    = 2'h0,
    CAUSE_LOW_VOLTAGE = 2'h1,
    CAUSE_EXT_PIN     = 2'h2,
    CAUSE_WATCHDOG    = 2'h3
  } ccr_cause_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANS  = 2'b10
  } ccr_bus_t;

  typedef struct packed {
    logic       fast_osc_en;
    logic       slow_osc_en;
    logic       watchdog_en;
    logic       reset_pin_sel;
    logic       src_slow;
    logic       reserved;
    logic [6:0] divide;
  } ccr_clk_t;

  typedef struct packed {
    ccr_bus_t    bus;
    logic [7:0]  rdata;
    logic [3:0]  flags;
    logic [7:0]  sp;
    logic [7:0]  clk_mode;
    logic [7:0]  irq_en;
    logic [7:0]  irq_req;
    logic [7:0]  timer_mode;
    logic [7:0]  aux_ctrl;
    logic [15:0] count;
    logic [5:0]  pre;
    logic        sel_bit_q;
    logic        ext_pin_q;
    logic        cnt_pin_q;
    logic        started;
    logic        retain;
  } ccr_state_t;

endpackage

// file: core/ccr_bank.sv
// How it works
// [RQ1] Any reset loads defaults and pulses a restart at address 0x00.
// [RQ2] Reset from external pin or watchdog flags data memory as retained.
// [RQ3] Status bits 7 to 4 always read as ones.
// [RQ4] Status bit 3 sets on signed overflow of add or subtract.
// [RQ5] Status bit 2 sets on low-nibble carry or borrow.
// [RQ6] Status bit 1 takes add carry, subtract borrow, or shift carry.
// [RQ7] Status bit 0 is set when the result is zero, else cleared; shift ops leave it unchanged.
// [RQ8] Stack pointer is read/write; software keeps bit 0 at zero.
// [RQ9] Type 0 clock codes: fast/4, fast/2, slow/4, slow undivided.
// [RQ10] Type 1 clock codes: fast/16, fast/8, slow/16, fast/32, fast/64.
// [RQ11] Clock-mode bit 4 enables fast oscillator, reset enabled.
// [RQ12] Clock-mode bit 2 enables slow oscillator; clearing stops watchdog.
// [RQ13] Clock-mode bit 1 enables watchdog, reset enabled.
// [RQ14] Clock-mode bit 0 selects port pin (0) or reset input (1).
// [RQ15] Interrupt enable bits 6, 4, 2, 0 gate the four sources.
// [RQ16] Request bits set by hardware, held until software clears them.
// [RQ17] Timer source field picks off, sys, pin falls, fast, slow.
// [RQ18] Timer prescaler divides by 1, 4, 16 or 64.
// [RQ19] Timer event comes from counter bit 8 plus select code.
// [RQ20] Edge select picks rising (0) or falling (1) counter-bit edge.
// [RQ21] External pin requests only while its digital input is enabled.
// [RQ22] Counter counts prescaled ticks and holds when source is off.
//
// Our own choice: the Avalon-MM interface to the registers.
module ccr_bank (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // Avalon-MM slave
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // Processor core
  input  wire ccr_pkg::ccr_alu_t    alu,
  input  wire ccr_pkg::ccr_cause_t  reset_cause,
  output logic      [7:0]           arith_flags,
  output logic      [7:0]           stack_pointer,
  output logic      [7:0]           irq_active,
  output logic                      restart,
  output logic      [15:0]          restart_addr,
  output logic                      mem_retain,
  // Clock and pin control
  output ccr_pkg::ccr_clk_t         clk_ctrl,
  // Event sources
  input  wire logic                 fast_osc_tick,
  input  wire logic                 slow_osc_tick,
  input  wire logic                 external_irq_pin,
  input  wire logic                 second_count_pin,
  input  wire logic                 second_timer_evt,
  input  wire logic                 comparator_evt,
  output logic      [15:0]          wide_timer_count
);
  import ccr_pkg::*;

  ccr_state_t s;
  ccr_state_t next_s;

  logic [3:0]  idx;
  logic        req;
  logic        wr_ok;
  logic [7:0]  wbyte;
  logic [7:0]  rd_mux;
  logic [3:0]  alu_flags;
  logic        tick_src;
  logic [5:0]  pre_limit;
  logic        tick;
  logic        sel_bit;
  logic        wide_evt;
  logic        ext_evt;
  logic [8:0]  sum9;
  logic [8:0]  dif9;
  logic [4:0]  nib_sum;

  assign idx   = avs_address[5:2];
  assign req   = avs_read | avs_write;
  assign wbyte = avs_writedata[7:0];

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    case (idx)
      IDX_FLAGS:      rd_mux = FLAGS_RSVD | {4'h0, s.flags}; // [RQ3]
      IDX_SP:         rd_mux = s.sp; // [RQ8]
      IDX_CLK_MODE:   rd_mux = s.clk_mode;
      IDX_IRQ_EN:     rd_mux = s.irq_en;
      IDX_IRQ_REQ:    rd_mux = s.irq_req;
      IDX_TIMER_MODE: rd_mux = s.timer_mode;
      IDX_AUX_CTRL:   rd_mux = s.aux_ctrl;
      IDX_COUNT_LO:   rd_mux = s.count[7:0];
      IDX_COUNT_HI:   rd_mux = s.count[15:8];
      default:        rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Arithmetic flags
  // ----------------------------------------------------------------
  assign sum9    = {1'b0, alu.a} + {1'b0, alu.b};
  assign dif9    = {1'b0, alu.a} - {1'b0, alu.b};
  assign nib_sum = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};

  always_comb begin
    alu_flags = s.flags;
    case (alu.op)
      ALU_ADD: begin
        alu_flags[3] = (alu.a[7] == alu.b[7]) & (sum9[7] != alu.a[7]); // [RQ4]
        alu_flags[2] = nib_sum[4]; // [RQ5]
        alu_flags[1] = sum9[8]; // [RQ6]
        alu_flags[0] = (sum9[7:0] == 8'h00); // [RQ7]
      end
      ALU_SUB: begin
        alu_flags[3] = (alu.a[7] != alu.b[7]) & (dif9[7] != alu.a[7]); // [RQ4]
        alu_flags[2] = (alu.a[3:0] < alu.b[3:0]); // [RQ5]
        alu_flags[1] = dif9[8]; // [RQ6]
        alu_flags[0] = (dif9[7:0] == 8'h00); // [RQ7]
      end
      ALU_LOGIC: begin
        alu_flags[0] = (alu.res == 8'h00); // [RQ7]
      end
      ALU_SHIFT: begin
        alu_flags[1] = alu.shift_c; // [RQ6]
      end
      default: begin
        alu_flags = s.flags;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Clock mode decode
  // ----------------------------------------------------------------
  always_comb begin
    clk_ctrl               = '0;
    clk_ctrl.fast_osc_en   = s.clk_mode[CLK_FAST_EN]; // [RQ11]
    clk_ctrl.slow_osc_en   = s.clk_mode[CLK_SLOW_EN]; // [RQ12]
    clk_ctrl.watchdog_en   = s.clk_mode[CLK_WDOG_EN] & s.clk_mode[CLK_SLOW_EN]; // [RQ12] [RQ13]
    clk_ctrl.reset_pin_sel = s.clk_mode[CLK_PIN_SEL]; // [RQ14]
    clk_ctrl.divide        = 7'h01;
    if (!s.clk_mode[CLK_TYPE]) begin
      case (s.clk_mode[7:5]) // [RQ9]
        3'h0:    clk_ctrl.divide = 7'h04;
        3'h1:    clk_ctrl.divide = 7'h02;
        3'h6: begin
          clk_ctrl.src_slow = 1'b1;
          clk_ctrl.divide   = 7'h04;
        end
        3'h7:    clk_ctrl.src_slow = 1'b1;
        default: clk_ctrl.reserved = 1'b1;
      endcase
    end else begin
      case (s.clk_mode[7:5]) // [RQ10]
        3'h0:    clk_ctrl.divide = 7'h10;
        3'h1:    clk_ctrl.divide = 7'h08;
        3'h2: begin
          clk_ctrl.src_slow = 1'b1;
          clk_ctrl.divide   = 7'h10;
        end
        3'h3:    clk_ctrl.divide = 7'h20;
        3'h4:    clk_ctrl.divide = 7'h40;
        default: clk_ctrl.reserved = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wide timer source, prescaler and event
  // ----------------------------------------------------------------
  always_comb begin
    case (s.timer_mode[7:5]) // [RQ17]
      TSRC_SYS:  tick_src = 1'b1;
      TSRC_PIN2: tick_src = s.cnt_pin_q & ~second_count_pin;
      TSRC_FAST: tick_src = fast_osc_tick & s.clk_mode[CLK_FAST_EN];
      TSRC_SLOW: tick_src = slow_osc_tick & s.clk_mode[CLK_SLOW_EN];
      TSRC_EXT:  tick_src = s.ext_pin_q & ~external_irq_pin;
      default:   tick_src = 1'b0;
    endcase
    case (s.timer_mode[4:3]) // [RQ18]
      2'h0:    pre_limit = PRE_DIV1;
      2'h1:    pre_limit = PRE_DIV4;
      2'h2:    pre_limit = PRE_DIV16;
      default: pre_limit = PRE_DIV64;
    endcase
  end

  // A stale count above a newly lowered limit ticks at once instead of wrapping
  assign tick     = tick_src & (s.pre >= pre_limit); // [RQ18]
  assign sel_bit  = s.count[4'h8 + {1'b0, s.timer_mode[2:0]}]; // [RQ19]
  assign wide_evt = s.aux_ctrl[AUX_T_EDGE] ? (s.sel_bit_q & ~sel_bit)
                                           : (~s.sel_bit_q & sel_bit); // [RQ20]
  // Any edge of the external pin, gated by its digital input enable
  assign ext_evt  = s.aux_ctrl[AUX_DIGIN_EN] & (s.ext_pin_q != external_irq_pin); // [RQ21]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_s.ext_pin_q = external_irq_pin;
    next_s.cnt_pin_q = second_count_pin;
    next_s.sel_bit_q = sel_bit;
    next_s.started   = 1'b1;

    // Cause caught in the first cycle after release
    if (!s.started) begin
      next_s.retain = (reset_cause == CAUSE_EXT_PIN) |
                      (reset_cause == CAUSE_WATCHDOG); // [RQ2]
    end

    // Prescaler and counter
    if (tick_src) begin
      next_s.pre = tick ? 6'h00 : s.pre + 6'h01; // [RQ18]
    end
    if (tick) begin
      next_s.count = s.count + 16'h0001; // [RQ22]
    end

    // Bus handshake: one wait cycle, then answer
    wr_ok = 1'b0;
    case (s.bus)
      BUS_IDLE: begin
        if (req) begin
          next_s.bus   = BUS_ANS;
          next_s.rdata = avs_read ? rd_mux : 8'h00;
        end
      end
      BUS_ANS: begin
        next_s.bus = BUS_IDLE;
        wr_ok      = avs_write & avs_byteenable[0];
      end
      default: begin
        next_s.bus = BUS_IDLE;
      end
    endcase

    if (wr_ok) begin
      case (idx)
        IDX_FLAGS:      next_s.flags      = wbyte[3:0];
        IDX_SP:         next_s.sp         = wbyte; // [RQ8]
        IDX_CLK_MODE:   next_s.clk_mode   = wbyte;
        IDX_IRQ_EN:     next_s.irq_en     = wbyte & IRQ_USED; // [RQ15]
        IDX_IRQ_REQ:    next_s.irq_req    = wbyte & IRQ_USED;
        IDX_TIMER_MODE: next_s.timer_mode = wbyte;
        IDX_AUX_CTRL:   next_s.aux_ctrl   = wbyte;
        default:        next_s.flags      = s.flags;
      endcase
    end

    // Hardware updates win over a software write in the same cycle
    if (alu.valid) begin
      next_s.flags = alu_flags;
    end
    next_s.irq_req[IRQ_SECOND] = next_s.irq_req[IRQ_SECOND] | second_timer_evt; // [RQ16]
    next_s.irq_req[IRQ_CMP]    = next_s.irq_req[IRQ_CMP] | comparator_evt; // [RQ16]
    next_s.irq_req[IRQ_WIDE]   = next_s.irq_req[IRQ_WIDE] | wide_evt; // [RQ16]
    next_s.irq_req[IRQ_EXT]    = next_s.irq_req[IRQ_EXT] | ext_evt; // [RQ16]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s            <= '0; // [RQ1]
      s.bus        <= BUS_IDLE;
      s.flags      <= RST_FLAGS;
      s.sp         <= RST_SP;
      s.clk_mode   <= RST_CLK_MODE; // [RQ11] [RQ12] [RQ13] [RQ14]
      s.irq_en     <= RST_IRQ_EN;
      s.irq_req    <= RST_IRQ_REQ;
      s.timer_mode <= RST_TIMER_MODE;
      s.aux_ctrl   <= RST_AUX_CTRL;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest  = req & (s.bus != BUS_ANS);
  assign avs_readdata     = {24'h000000, s.rdata};
  assign arith_flags      = FLAGS_RSVD | {4'h0, s.flags}; // [RQ3]
  assign stack_pointer    = s.sp;
  assign irq_active       = s.irq_req & s.irq_en; // [RQ15]
  assign restart          = ~s.started; // [RQ1]
  assign restart_addr     = RESTART_ADDR; // [RQ1]
  assign mem_retain       = s.retain;
  assign wide_timer_count = s.count;

endmodule // ccr_bank

// file: bench/ccr_bank_properties.sv
module ccr_bank_properties
  import ccr_pkg::*;
(
  // Clock, reset and bus
  input wire logic                core_clk,
  input wire logic                nrst,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic                avs_waitrequest,
  // Core side
  input wire ccr_pkg::ccr_alu_t   alu,
  input wire logic [7:0]          arith_flags,
  input wire logic [7:0]          irq_active,
  input wire logic                restart,
  input wire logic [15:0]         restart_addr,
  input wire ccr_pkg::ccr_clk_t   clk_ctrl,
  input wire logic [15:0]         wide_timer_count
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic add_go;
  assign add_go = alu.valid && alu.op == ALU_ADD;
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans) else $error("bus answer late");
  a_flags_ones: assert property (arith_flags[7:4] == 4'hf) else $error("flag top");
  a_zero_flag: assert property (alu.valid && alu.op != ALU_SHIFT |=>
    arith_flags[0] == ($past(alu.res) == 8'h00)) else $error("zero flag");
  a_add_carry: assert property (add_go |=>
    arith_flags[1] == ($past({1'b0, alu.a} + {1'b0, alu.b}) > 9'h0ff)) else $error("carry");
  a_half_carry: assert property (add_go |=> arith_flags[2] ==
    ($past({1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]}) > 5'h0f)) else $error("half carry");
  a_add_overflow: assert property (add_go && alu.a[7] == alu.b[7] &&
    alu.res[7] != alu.a[7] |=> arith_flags[3]) else $error("overflow");
  a_restart_once: assert property (!restart |=> !restart) else $error("restart");
  a_restart_addr: assert property (restart_addr == 16'h0000) else $error("addr");
  a_wdog_slow: assert property (clk_ctrl.watchdog_en |-> clk_ctrl.slow_osc_en)
    else $error("watchdog without slow osc");
  a_irq_reserved: assert property ((irq_active & 8'haa) == 8'h00) else $error("irq");
  a_irq_sticky: assert property ($fell(irq_active[4]) |->
    $past(avs_write && !avs_waitrequest)) else $error("request dropped");
  a_count_step: assert property (wide_timer_count != $past(wide_timer_count) |->
    wide_timer_count == $past(wide_timer_count) + 16'h0001) else $error("count step");
endmodule // ccr_bank_properties

bind ccr_bank ccr_bank_properties u_props (.core_clk, .nrst, .avs_read, .avs_write,
  .avs_waitrequest, .alu, .arith_flags, .irq_active, .restart, .restart_addr, .clk_ctrl,
  .wide_timer_count);

// file: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import ccr_pkg::*;
  logic        core_clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        avs_waitrequest, restart, mem_retain;
  ccr_alu_t    alu = '0;
  ccr_cause_t  reset_cause = CAUSE_POWER_ON;
  ccr_clk_t    clk_ctrl;
  logic [7:0]  arith_flags, stack_pointer, irq_active, r;
  logic [15:0] restart_addr, wide_timer_count, c0;
  logic        fast_osc_tick = 0, external_irq_pin = 0, second_timer_evt = 0, comparator_evt = 0;
  logic        slow_osc_tick = 0, second_count_pin = 0;
  logic [7:0]  cw [11] = '{8'h16, 8'h36, 8'hd6, 8'hf6, 8'h1e, 8'h3e, 8'h5e, 8'h7e, 8'h9e,
                           8'h56, 8'hbe};
  logic [8:0]  ce [11] = '{9'h004, 9'h002, 9'h104, 9'h101, 9'h010, 9'h008, 9'h110, 9'h020,
                           9'h040, 9'h081, 9'h081};
  int          fails = 0, n_checks = 0, cycles = 0;

  ccr_bank u_dut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .alu, .reset_cause, .arith_flags,
    .stack_pointer, .irq_active, .restart, .restart_addr, .mem_retain, .clk_ctrl,
    .fast_osc_tick, .slow_osc_tick, .external_irq_pin, .second_count_pin,
    .second_timer_evt, .comparator_evt, .wide_timer_count);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) fast_osc_tick <= ~fast_osc_tick;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  // ----
  // Shared tasks
  // ----
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(logic wr, logic [3:0] idx, logic [7:0] wd);
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    // Request stands until waitrequest is seen low at a rising edge
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_read <= 0;
    avs_write <= 0;
    // Let a write settle before callers look at outputs
    @(negedge core_clk);
  endtask

  task automatic do_reset(ccr_cause_t c);
    @(posedge core_clk);
    nrst <= 0;
    reset_cause <= c;
    repeat (6) @(posedge core_clk);
    chk(restart, 1);
    chk(restart_addr, 16'h0000);
    nrst <= 1;
    repeat (2) @(negedge core_clk);
    chk(restart, 0);
    chk(mem_retain, c[1]);
  endtask

  task automatic alu_do(ccr_alu_op_t op, logic [7:0] a, b, res, logic sc, logic [7:0] m, e);
    @(posedge core_clk);
    alu <= '{1'b1, op, a, b, res, sc};
    @(posedge core_clk);
    alu.valid <= 0;
    @(negedge core_clk);
    chk(arith_flags & m, e);
  endtask

  task automatic pin_flip();
    @(posedge core_clk);
    external_irq_pin <= ~external_irq_pin;
    repeat (3) @(negedge core_clk);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    for (int i = 3; i >= 0; i--) do_reset(ccr_cause_t'(i));
    bus(0, 4'h0, 0); chk(r, 8'hf0);
    bus(0, 4'h3, 0); chk(r, 8'hf6);
    chk({clk_ctrl.src_slow, clk_ctrl.divide}, 8'h81);
    chk({clk_ctrl.fast_osc_en, clk_ctrl.slow_osc_en, clk_ctrl.watchdog_en}, 3'h7);
    chk(clk_ctrl.reset_pin_sel, 0);
    bus(0, 4'h6, 0); chk(r, 8'h00);
  endtask

  task automatic t_alu();
    alu_do(ALU_ADD, 8'h80, 8'h80, 8'h00, 0, 8'hff, 8'hfb);
    alu_do(ALU_ADD, 8'h0f, 8'h01, 8'h10, 0, 8'hff, 8'hf4);
    alu_do(ALU_SUB, 8'h10, 8'h01, 8'h0f, 0, 8'hff, 8'hf4);
    alu_do(ALU_SUB, 8'h00, 8'h01, 8'hff, 0, 8'hff, 8'hf6);
    alu_do(ALU_SUB, 8'h80, 8'h01, 8'h7f, 0, 8'hff, 8'hfc);
    alu_do(ALU_LOGIC, 8'h0f, 8'hf0, 8'h00, 0, 8'h01, 8'h01);
    alu_do(ALU_SHIFT, 8'h81, 8'h00, 8'h02, 1, 8'h02, 8'h02);
    bus(1, 4'h0, 8'h00); bus(0, 4'h0, 0); chk(r, 8'hf0);
  endtask

  task automatic t_sp();
    bus(1, 4'h2, 8'h3e); bus(0, 4'h2, 0); chk(r, 8'h3e);
    chk(stack_pointer, 8'h3e);
    @(posedge core_clk);
    avs_byteenable <= 4'h0;
    bus(1, 4'h2, 8'hfe);
    @(posedge core_clk);
    avs_byteenable <= 4'hf;
    bus(0, 4'h2, 0); chk(r, 8'h3e);
    bus(1, 4'h1, 8'h55); bus(0, 4'h1, 0); chk(r, 8'h00);
  endtask

  task automatic t_clock();
    for (int i = 0; i < 11; i++) begin
      bus(1, 4'h3, cw[i]); bus(0, 4'h3, 0); chk(r, cw[i]);
      chk({clk_ctrl.reserved, clk_ctrl.divide}, ce[i][7:0]);
      if (i < 9) chk(clk_ctrl.src_slow, ce[i][8]);
    end
    bus(1, 4'h3, 8'hf3);
    chk({clk_ctrl.fast_osc_en, clk_ctrl.slow_osc_en, clk_ctrl.watchdog_en,
         clk_ctrl.reset_pin_sel}, 4'h9);
    bus(1, 4'h3, 8'he6);
    chk({clk_ctrl.fast_osc_en, clk_ctrl.slow_osc_en, clk_ctrl.watchdog_en,
         clk_ctrl.reset_pin_sel}, 4'h6);
    bus(1, 4'h3, 8'hf4);
  endtask

  task automatic t_irq();
    bus(1, 4'h4, 8'hff); bus(0, 4'h4, 0); chk(r, 8'h55);
    @(posedge core_clk);
    second_timer_evt <= 1;
    comparator_evt <= 1;
    @(posedge core_clk);
    second_timer_evt <= 0;
    comparator_evt <= 0;
    repeat (4) @(negedge core_clk);
    chk(irq_active, 8'h50);
    pin_flip(); chk(irq_active, 8'h51);
    bus(1, 4'h5, 8'h00); chk(irq_active, 8'h00);
    bus(1, 4'h7, 8'h00); pin_flip(); chk(irq_active, 8'h00);
    bus(1, 4'h7, 8'h01); pin_flip(); chk(irq_active, 8'h01);
    bus(1, 4'h4, 8'h00); chk(irq_active, 8'h00);
    bus(0, 4'h5, 0); chk(r, 8'h01);
    bus(1, 4'h5, 8'h00);
  endtask

  task automatic t_timer();
    for (int p = 0; p < 4; p++) begin
      bus(1, 4'h6, {3'h1, 2'(p), 3'h0});
      @(negedge core_clk);
      c0 = wide_timer_count;
      repeat (10 << (2 * p)) @(negedge core_clk);
      chk(wide_timer_count - c0, 16'h000a);
    end
    // Rising edge of counter bit 8
    bus(1, 4'h6, 8'h20);
    bus(1, 4'h5, 8'h00);
    bus(0, 4'h5, 0); chk(r, 8'h00);
    while (!wide_timer_count[8]) @(negedge core_clk);
    bus(0, 4'h5, 0); chk(r, 8'h04);
    // Rising edge of counter bit 9
    bus(1, 4'h6, 8'h21);
    bus(1, 4'h5, 8'h00);
    bus(0, 4'h5, 0); chk(r, 8'h00);
    while (!wide_timer_count[9]) @(negedge core_clk);
    bus(0, 4'h5, 0); chk(r, 8'h04);
    // Falling edge of counter bit 9
    bus(1, 4'h7, 8'h11);
    bus(1, 4'h5, 8'h00);
    bus(0, 4'h5, 0); chk(r, 8'h00);
    while (wide_timer_count[9]) @(negedge core_clk);
    bus(0, 4'h5, 0); chk(r, 8'h04);
    bus(1, 4'h7, 8'h01);
    bus(1, 4'h6, 8'h80);
    @(negedge core_clk);
    c0 = wide_timer_count;
    repeat (20) @(negedge core_clk);
    chk(wide_timer_count - c0, 16'h000a);
    bus(1, 4'h6, 8'h00);
    @(negedge core_clk);
    c0 = wide_timer_count;
    repeat (20) @(negedge core_clk);
    chk(wide_timer_count, c0);
    bus(0, 4'h8, 0); chk(r, c0[7:0]);
    bus(0, 4'h9, 0); chk(r, c0[15:8]);
  endtask

  // Ten high-low pulses on one source input, counted by the wide timer
  task automatic t_src(logic [7:0] mode, logic [2:0] sel);
    bus(1, 4'h6, mode);
    c0 = wide_timer_count;
    repeat (10) begin
      @(posedge core_clk);
      {external_irq_pin, second_count_pin, slow_osc_tick} <= sel;
      @(posedge core_clk);
      {external_irq_pin, second_count_pin, slow_osc_tick} <= 3'h0;
    end
    repeat (2) @(negedge core_clk);
    chk(wide_timer_count - c0, 16'h000a);
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    t_reset();
    t_alu();
    t_sp();
    t_clock();
    t_irq();
    t_timer();
    t_src(8'hc0, 3'h1);
    t_src(8'h60, 3'h2);
    t_src(8'he0, 3'h4);
    conclude();
  end
endmodule // testbench
